/* core/hcl_loader.sv */
// Hub configuration image loader: reads the start-up image byte by byte
// and holds the fields that feed the hub descriptors.
// Assumes an image reader that answers rd_req with one rd_valid per byte,
// and an APB master on the register side.
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module hcl_loader #(
   parameter int ADDR_W = 11
) (
   // Clock, reset and enable.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Image reader.
   output logic rd_req,
   output logic [ADDR_W-1:0] rd_addr,
   input wire logic rd_valid,
   input wire logic [7:0] rd_data,
   // Hub side.
   output logic cfg_done,
   output logic vendor_class_mode,
   output logic [15:0] vendor_id,
   output logic [15:0] product_id,
   output logic [15:0] device_release_id,
   output logic [3:0] enabled_port_oc_filter_ms,
   output logic [3:0] disabled_port_oc_filter_ms,
   output logic [7:0] upstream_bus_current_units,
   output logic [7:0] controller_current_ma,
   output logic [7:0] language_count,
   output logic [ADDR_W-1:0] manufacturer_table_addr,
   output logic [ADDR_W-1:0] product_table_addr
);
   import hcl_pkg::*;

   // ==========================================================
   // Loader state
   hcl_state_t state_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic ext_reg, blank_reg, done_reg;
   logic [7:0] img_reg [0:IMG_LAST];
   logic [2:0] ctrl_reg;
   logic [31:0] fuse_reg, fuse_pwr_reg;
   logic [31:0] prdata_reg;

   // Writes take effect in the single APB access cycle.
   wire apb_wr = psel & penable & pwrite & clk_en;
   wire apb_rd = psel & penable & ~pwrite & clk_en;
   wire mapped = (paddr <= REG_FUSE_PWR) & (paddr[1:0] == 2'b00);
   wire use_fuse = ctrl_reg[CTRL_USE_FUSE];
   wire self_pwr = ctrl_reg[CTRL_SELF_PWR];
   wire high_speed = ctrl_reg[CTRL_HIGH_SPEED];
   wire last_byte = (addr_reg == ADDR_W'(IMG_LAST));
   wire take = (state_reg == HCL_WAIT) & rd_valid;

   // Helper: a loaded image byte, or a default until extended layout seen.
   function automatic logic [7:0] fld(input logic [7:0] v,
                                      input logic [7:0] d);
      fld = ext_reg ? v : d;
   endfunction : fld

   // Sequencer walks the image in ascending order, once after reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= HCL_IDLE;
         addr_reg <= '0;
         ext_reg <= 1'b0;
         blank_reg <= 1'b0;
         done_reg <= 1'b0;
      end else if (clk_en) begin
         case (state_reg)
            HCL_IDLE: begin
               if (use_fuse) begin
                  done_reg <= 1'b1;
                  state_reg <= HCL_DONE;
               end else begin
                  state_reg <= HCL_REQ;
               end
            end
            HCL_REQ: state_reg <= HCL_WAIT;
            HCL_WAIT: begin
               if (rd_valid) begin
                  if (addr_reg == '0) begin
                     ext_reg <= (rd_data == SIGNATURE);
                     blank_reg <= (rd_data == BLANK_BYTE);
                  end
                  // A non-signature first byte stops the walk early.
                  if (last_byte || (addr_reg == '0 && rd_data != SIGNATURE))
                  begin
                     state_reg <= HCL_DONE;
                     done_reg <= 1'b1;
                  end else begin
                     addr_reg <= addr_reg + 1'b1;
                     state_reg <= HCL_REQ;
                  end
               end
            end
            HCL_DONE: state_reg <= HCL_DONE;
            default: state_reg <= HCL_IDLE;
         endcase
      end
   end

   // Image byte store, indexed by address.
   genvar gi;
   generate
      for (gi = 0; gi <= IMG_LAST; gi++) begin : g_img
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               img_reg[gi] <= 8'h00;
            end else if (clk_en && take && addr_reg == ADDR_W'(gi)) begin
               img_reg[gi] <= rd_data;
            end
         end
      end
   endgenerate

   // Software control and fuse image registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= 3'h0;
         fuse_reg <= {DEF_PID, DEF_VID};
         fuse_pwr_reg <= {DEF_HC_HS, DEF_HC_FS, DEF_MP_HS, DEF_MP_FS};
      end else if (apb_wr && !done_reg) begin
         // Fuse content is frozen once the loader has finished.
         if (paddr == REG_FUSE) fuse_reg <= pwdata;
         if (paddr == REG_FUSE_PWR) fuse_pwr_reg <= pwdata;
         if (paddr == REG_CTRL) ctrl_reg <= pwdata[2:0];
      end else if (apb_wr && paddr == REG_CTRL) begin
         // Speed and power source may change after load.
         ctrl_reg[2:1] <= pwdata[2:1];
      end
   end

   // ==========================================================
   // Field extraction
   wire fuse_sel = use_fuse;
   wire [15:0] vid_w = fuse_sel ? fuse_reg[15:0]
      : {fld(img_reg[IMG_VID_HI], DEF_VID[15:8]),
         fld(img_reg[IMG_VID_LO], DEF_VID[7:0])};
   wire [15:0] pid_w = fuse_sel ? fuse_reg[31:16]
      : {fld(img_reg[IMG_PID_HI], DEF_PID[15:8]),
         fld(img_reg[IMG_PID_LO], DEF_PID[7:0])};
   // Byte five is reserved and never read into a field.
   wire [15:0] rel_w = {fld(img_reg[IMG_REL_HI], DEF_REL[15:8]),
                        DEF_REL[7:0]};
   wire [7:0] oc_w = fld(img_reg[IMG_OC], DEF_OC);
   wire [7:0] mp_fs = fuse_sel ? fuse_pwr_reg[7:0]
      : fld(img_reg[IMG_MP_FS], DEF_MP_FS);
   wire [7:0] mp_hs = fuse_sel ? fuse_pwr_reg[15:8]
      : fld(img_reg[IMG_MP_HS], DEF_MP_HS);
   wire [7:0] hc_fs_bus = fuse_sel ? fuse_pwr_reg[23:16]
      : fld(img_reg[IMG_HC_FS_BUS], DEF_HC_FS);
   wire [7:0] hc_hs_bus = fuse_sel ? fuse_pwr_reg[31:24]
      : fld(img_reg[IMG_HC_HS_BUS], DEF_HC_HS);
   wire [7:0] hc_fs_self = fld(img_reg[IMG_HC_FS_SELF], DEF_HC_FS);
   wire [7:0] hc_hs_self =
      fld(img_reg[IMG_HC_HS_SELF], DEF_HC_HS_SELF);
   wire [7:0] langs = fld(img_reg[IMG_LANG], 8'h00);
   // Tables step by twice the language count, entries low byte first.
   wire [ADDR_W-1:0] step = ADDR_W'({langs, 1'b0});
   wire [ADDR_W-1:0] tab_a = ADDR_W'(IMG_LANG_ARRAY) + step;
   wire [ADDR_W-1:0] tab_b = tab_a + step;

   // Hub outputs: zero until loading is complete, so nothing is shown early.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vendor_id <= 16'h0000;
         product_id <= 16'h0000;
         device_release_id <= 16'h0000;
         enabled_port_oc_filter_ms <= 4'h0;
         disabled_port_oc_filter_ms <= 4'h0;
         upstream_bus_current_units <= 8'h00;
         controller_current_ma <= 8'h00;
         language_count <= 8'h00;
         manufacturer_table_addr <= '0;
         product_table_addr <= '0;
      end else if (clk_en && done_reg) begin
         vendor_id <= vid_w;
         product_id <= pid_w;
         device_release_id <= rel_w;
         enabled_port_oc_filter_ms <= oc_w[7:4];
         disabled_port_oc_filter_ms <= oc_w[3:0];
         upstream_bus_current_units <= high_speed ? mp_hs : mp_fs;
         controller_current_ma <= self_pwr
            ? (high_speed ? hc_hs_self : hc_fs_self)
            : (high_speed ? hc_hs_bus : hc_fs_bus);
         language_count <= langs;
         manufacturer_table_addr <= tab_a;
         product_table_addr <= tab_b;
      end
   end

   // Done is delayed one cycle so outputs are valid when it rises.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_done <= 1'b0;
         vendor_class_mode <= 1'b0;
      end else if (clk_en) begin
         cfg_done <= done_reg;
         vendor_class_mode <= done_reg & blank_reg & ~use_fuse;
      end
   end

   // ==========================================================
   // Image reader port
   assign rd_req = (state_reg == HCL_REQ);
   assign rd_addr = addr_reg;

   // ==========================================================
   // APB read mux, registered in the setup cycle
   wire [31:0] rd_mux =
      (paddr == REG_CTRL) ? {29'h0, ctrl_reg} :
      (paddr == REG_STATUS) ? {28'h0, vendor_class_mode, blank_reg,
                               ext_reg, cfg_done} :
      (paddr == REG_IDS) ? {product_id, vendor_id} :
      (paddr == REG_REL) ? {8'h00, language_count, device_release_id} :
      (paddr == REG_POWER) ? {16'h0, enabled_port_oc_filter_ms,
                              disabled_port_oc_filter_ms,
                              upstream_bus_current_units} :
      (paddr == REG_CTRLCUR) ? {24'h0, controller_current_ma} :
      (paddr == REG_STRTAB) ? {5'h0, product_table_addr,
                               5'h0, manufacturer_table_addr} :
      (paddr == REG_FUSE) ? fuse_reg :
      (paddr == REG_FUSE_PWR) ? fuse_pwr_reg : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0;
      end else if (psel && !penable && clk_en) begin
         prdata_reg <= rd_mux;
      end
   end

   // Zero wait states; data was captured in the setup cycle.
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = (apb_rd && mapped) ? prdata_reg : 32'h0;
endmodule : hcl_loader

/* core/hcl_pkg.sv */
// Constants for the hub configuration image loader.
// Assumes a byte-wide image reader and an APB register interface.
package hcl_pkg;
   // ==========================================================
   // Image layout
   localparam logic [7:0] SIGNATURE = 8'hd4;
   localparam logic [7:0] BLANK_BYTE = 8'hff;
   localparam int IMG_VID_LO = 1;
   localparam int IMG_VID_HI = 2;
   localparam int IMG_PID_LO = 3;
   localparam int IMG_PID_HI = 4;
   localparam int IMG_REL_HI = 6;
   localparam int IMG_OC = 7;
   localparam int IMG_MP_FS = 8;
   localparam int IMG_MP_HS = 9;
   localparam int IMG_HC_FS_BUS = 12;
   localparam int IMG_HC_HS_BUS = 13;
   localparam int IMG_HC_FS_SELF = 14;
   localparam int IMG_HC_HS_SELF = 15;
   localparam int IMG_LANG = 20;
   localparam int IMG_LANG_ARRAY = 24;
   localparam int IMG_LAST = 24;
   // ==========================================================
   // Defaults used until a valid image is loaded; the low byte of DEF_REL is used always
   localparam logic [7:0] DEF_OC = 8'h88;
   localparam logic [7:0] DEF_MP_FS = 8'h28;
   localparam logic [7:0] DEF_MP_HS = 8'h57;
   localparam logic [7:0] DEF_HC_FS = 8'h50;
   localparam logic [7:0] DEF_HC_HS = 8'hae;
   localparam logic [7:0] DEF_HC_HS_SELF = 8'h64;
   localparam logic [15:0] DEF_VID = 16'h1234; // Arbitrary value.
   localparam logic [15:0] DEF_PID = 16'h5678; // Arbitrary value.
   localparam logic [15:0] DEF_REL = 16'h0100; // Arbitrary value.
   // ==========================================================
   // APB register offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_IDS = 8'h08;
   localparam logic [7:0] REG_REL = 8'h0c;
   localparam logic [7:0] REG_POWER = 8'h10;
   localparam logic [7:0] REG_CTRLCUR = 8'h14;
   localparam logic [7:0] REG_STRTAB = 8'h18;
   localparam logic [7:0] REG_FUSE = 8'h1c;
   localparam logic [7:0] REG_FUSE_PWR = 8'h20;
   localparam int CTRL_USE_FUSE = 0;
   localparam int CTRL_SELF_PWR = 1;
   localparam int CTRL_HIGH_SPEED = 2;
   typedef enum logic [1:0] {HCL_IDLE, HCL_REQ, HCL_WAIT, HCL_DONE}
      hcl_state_t;
endpackage : hcl_pkg

/* sim/hcl_properties.sv */
// Port checker for the image loader.
// Assumes a bind to hcl_loader from the bench top.
`timescale 1ns/1ps
module hcl_properties
   import hcl_pkg::*;
#(
   parameter int ADDR_W = 11
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Register bus.
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pslverr,
   // Image reader.
   input wire logic rd_req,
   input wire logic [ADDR_W-1:0] rd_addr,
   input wire logic rd_valid,
   input wire logic [7:0] rd_data,
   // Hub side.
   input wire logic cfg_done,
   input wire logic [15:0] vendor_id,
   input wire logic [3:0] enabled_port_oc_filter_ms,
   input wire logic [3:0] disabled_port_oc_filter_ms
);
   // ========
   // Helper state
   logic [7:0] img [0:7];
   logic seen_reg;
   logic [ADDR_W-1:0] last_reg;
   logic bad_a;
   logic img_ok;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Decoded conditions used by the properties below.
   assign bad_a = paddr > 8'h20 || paddr[1:0] != 2'b00;
   assign img_ok = cfg_done && img[0] == SIGNATURE;
   // Last address asked for, so order can be judged per request.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen_reg <= 1'b0;
         last_reg <= '0;
      end else if (rd_req) begin
         seen_reg <= 1'b1;
         last_reg <= rd_addr;
      end
   end
   // Copy of the image head; no reset, it is only read once loaded.
   always_ff @(posedge pclk) begin
      if (rd_valid && rd_addr[ADDR_W-1:3] == '0) begin
         img[rd_addr[2:0]] <= rd_data;
      end
   end
   // ========
   // Properties
   a_bad_addr: assert property (psel && penable && bad_a |-> pslverr)
      else $error("no error on unmapped access");
   a_req_pulse: assert property (rd_req |=> !rd_req)
      else $error("read request longer than one cycle");
   a_addr_order: assert property (rd_req |->
      rd_addr == (seen_reg ? last_reg + 1'b1 : '0))
      else $error("image read out of order");
   a_addr_hold: assert property (
      rd_req ##1 !rd_valid |=> $stable(rd_addr))
      else $error("read address moved while waiting");
   a_stop_nosig: assert property (rd_valid && rd_addr == '0 &&
      rd_data != SIGNATURE |=> !rd_req [*8])
      else $error("reading went on without signature");
   a_done_holds: assert property (cfg_done |=> cfg_done)
      else $error("done fell");
   a_idle_zero: assert property (!cfg_done |-> vendor_id == '0)
      else $error("field shown before load done");
   a_vid_bytes: assert property (img_ok |->
      vendor_id == {img[2], img[1]})
      else $error("vendor id bytes wrong");
   a_oc_nibbles: assert property (img_ok |->
      {enabled_port_oc_filter_ms, disabled_port_oc_filter_ms} == img[7])
      else $error("filter nibbles wrong");
endmodule : hcl_properties

/* sim/hcl_rom.sv */
// Byte-wide image memory answering the loader's read requests.
// Assumes one request at a time; the bench fills mem and sets lat.
`timescale 1ns/1ps
module hcl_rom #(
   parameter int ADDR_W = 11
) (
   // Clock.
   input wire logic pclk,
   // Read request and answer.
   input wire logic rd_req,
   input wire logic [ADDR_W-1:0] rd_addr,
   output logic rd_valid,
   output logic [7:0] rd_data
);
   logic [7:0] mem [0:31];
   int lat = 1;
   int cnt = 0;
   logic pend = 1'b0;
   // ========
   // Answer after lat cycles; idle data toggles so stale bytes show.
   initial begin
      rd_valid = 1'b0;
      rd_data = 8'h00;
   end
   always @(posedge pclk) begin
      rd_valid <= 1'b0;
      rd_data <= ~rd_data;
      if (rd_req) begin
         pend <= 1'b1;
         cnt <= lat;
      end else if (pend && cnt > 1) begin
         cnt <= cnt - 1;
      end else if (pend) begin
         pend <= 1'b0;
         rd_valid <= 1'b1;
         rd_data <= mem[rd_addr[4:0]];
      end
   end
endmodule : hcl_rom

/* sim/testbench.sv */
// Bench top: loader, image memory model and APB read/write tasks.
// Assumes hcl_pkg, hcl_loader, hcl_rom and the checker compiled first.
`timescale 1ns/1ps
module testbench;
   import hcl_pkg::*;
   logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
   logic rd_req, rd_valid, cfg_done, vcm, perr;
   logic [7:0] paddr, rd_data, bc, cc, lc;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] vid, pid, rel;
   logic [3:0] eo, dof;
   logic [10:0] rd_addr, mt, pt;
   int fails = 0;
   int checks_done = 0;
   // ========
   // Clock, design and image memory
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   hcl_loader u_hcl_loader (.pclk(pclk), .presetn(presetn),
      .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rd_req(rd_req), .rd_addr(rd_addr),
      .rd_valid(rd_valid), .rd_data(rd_data), .cfg_done(cfg_done),
      .vendor_class_mode(vcm), .vendor_id(vid), .product_id(pid),
      .device_release_id(rel), .enabled_port_oc_filter_ms(eo),
      .disabled_port_oc_filter_ms(dof), .upstream_bus_current_units(bc),
      .controller_current_ma(cc), .language_count(lc),
      .manufacturer_table_addr(mt), .product_table_addr(pt));
   hcl_rom u_hcl_rom (.pclk(pclk), .rd_req(rd_req), .rd_addr(rd_addr),
      .rd_valid(rd_valid), .rd_data(rd_data));
   // ========
   // Tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Setup then access; request held until pready is seen high.
   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge pclk);
      end
      // A slave that never answers counts as a mismatch.
      if (n >= 50) fails++;
      q = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // One idle edge, so a following call never drives psel twice at once.
      @(posedge pclk);
   endtask : apb
   // Reset for 12 cycles, then wait a bounded time for the load.
   task automatic load(input int lat);
      int n;
      n = 0;
      u_hcl_rom.lat = lat;
      presetn <= 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      // Done is looked at on the falling edge, where it has settled.
      while (cfg_done !== 1'b1 && n < 500) begin
         n++;
         @(negedge pclk);
      end
      chk(32'(cfg_done), 32'h1);
      @(posedge pclk);
   endtask : load
   task automatic print_verdict();
      $display("checks=%0d fails=%0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : print_verdict
   // ========
   // Tests
   initial begin
      presetn = 1'b0;
      clk_en = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      for (int i = 0; i < 32; i++) u_hcl_rom.mem[i] = 8'h10 + 8'(i);
      u_hcl_rom.mem[0] = SIGNATURE;
      u_hcl_rom.mem[7] = 8'hf0;
      u_hcl_rom.mem[10] = 8'h00;
      u_hcl_rom.mem[11] = 8'h00;
      u_hcl_rom.mem[20] = 8'h03;
      load(1);
      chk(pid, 32'h1413);
      chk(rel, 32'h1600);
      chk(mt, 32'd30);
      chk(pt, 32'd36);
      apb(1'b0, REG_IDS, 32'h0);
      chk(q, 32'h14131211);
      apb(1'b0, REG_STATUS, 32'h0);
      chk(q, 32'h3);
      apb(1'b0, 8'h24, 32'h0);
      chk(q, 32'h0);
      chk(32'(perr), 32'h1);
      // Every speed and power combination selects its own bytes.
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, REG_CTRL, 32'(m * 2));
         repeat (3) @(posedge pclk);
         chk(bc, 32'(8'h18 + m / 2));
         chk(cc, 32'(8'h1c + 2 * (m % 2) + m / 2));
      end
      for (int i = 0; i < 32; i++) u_hcl_rom.mem[i] = BLANK_BYTE;
      load(3);
      chk(vcm, 32'h1);
      chk(vid, DEF_VID);
      chk({eo, dof}, DEF_OC);
      chk(bc, DEF_MP_FS);
      chk(cc, DEF_HC_FS);
      print_verdict();
   end
   // A hang ends the run as a mismatch.
   initial begin
      #2000000;
      fails++;
      print_verdict();
   end
endmodule : testbench
bind hcl_loader hcl_properties #(.ADDR_W(ADDR_W)) u_hcl_properties (.*);
